// File: src/bss_sequencer.sv
// Buck soft-start, power-good and fault sequencer
//
// Behaviour
// - Start only with supplies and enable good
// - Charge to supply until comp passes ramp
// - First enable: 200ns low-side boot phase
// - After enable, target switches to margined reference
// - Done when enabled and node settled
// - Power good waits for soft-start done
// - Extra delay before power good asserts
// - Power good drops at once on voltage or sourcing fault
// - Voltage faults ignored until soft-start done
// - Overvoltage forces zero duty, overrides overcurrent
// - Undervoltage only drops power good
// - Overcurrent enabled with drivers, peak per period
// - Blank current comparators at conduction start
// - Filter comparator result before accepting fault
// - Low-side sourcing fault above inverted limit
// - Low-side sinking fault at same limit
// - High-side sourcing fault above resistor drop
// - Sourcing fault: gates off, three hiccup cycles
// - Sinking fault: low side off three cycles
// - 32 cycles without low pulse forces refresh
`timescale 1ns/1ps
module bss_sequencer #(
  parameter int unsigned GOOD_DELAY_CYC = bss_pkg::GOOD_DELAY_CYC
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Comparator results
  input  wire bss_pkg::bss_cmp_s cmp_in,
  // Switching clock edge and PWM demand
  input  wire logic             sw_tick,
  input  wire logic             pwm_high,
  // Driver, soft-start and status outputs
  output logic                  high_gate_drive,
  output logic                  low_gate_drive,
  output logic                  ss_charge_en,
  output logic                  ss_discharge,
  output logic                  ss_target_ref,
  output logic                  ss_done,
  output logic                  power_ok_output_n,
  output logic                  overvoltage_flag,
  output logic                  undervoltage_flag,
  output logic                  overcurrent_protect
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  bss_pkg::bss_cmp_s cmp_m_r;
  bss_pkg::bss_cmp_s cmp_r;

  // Two-stage sync of comparator bundle
  // double flop sync
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmp_m_r <= '0;
      cmp_r   <= '0;
    end else begin
      cmp_m_r <= cmp_in;
      cmp_r   <= cmp_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state

  bss_pkg::bss_state_e state_r;
  logic [bss_pkg::CNT_W-1:0] boot_cnt_r;
  logic [1:0]                hiccup_cnt_r;
  logic                      ss_dir_up_r;
  logic                      src_fault;
  logic                      power_ok;
  logic                      drivers_on;

  assign power_ok   = cmp_r.supplies_ok && cmp_r.enable_ok;
  assign drivers_on = (state_r == bss_pkg::ST_RAMP) || (state_r == bss_pkg::ST_RUN) ||
                      (state_r == bss_pkg::ST_BOOT);

  // Main sequencing machine
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= bss_pkg::ST_IDLE;
    end else if (!power_ok) begin
      state_r <= bss_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        bss_pkg::ST_IDLE: begin
          state_r <= bss_pkg::ST_CHARGE;
        end
        bss_pkg::ST_CHARGE: begin
          if (cmp_r.comp_above_ramp) begin
            state_r <= bss_pkg::ST_BOOT;
          end
        end
        bss_pkg::ST_BOOT: begin
          if (src_fault) begin
            state_r <= bss_pkg::ST_HICCUP;
          end else if (boot_cnt_r == bss_pkg::CNT_W'(bss_pkg::BOOT_CHARGE_CYC - 1)) begin
            state_r <= bss_pkg::ST_RAMP;
          end
        end
        bss_pkg::ST_RAMP: begin
          if (src_fault) begin
            state_r <= bss_pkg::ST_HICCUP;
          end else if (cmp_r.ss_settled) begin
            state_r <= bss_pkg::ST_RUN;
          end
        end
        bss_pkg::ST_RUN: begin
          if (src_fault) begin
            state_r <= bss_pkg::ST_HICCUP;
          end
        end
        bss_pkg::ST_HICCUP: begin
          if (hiccup_cnt_r == 2'(bss_pkg::HICCUP_CYCLES) && cmp_r.ss_low && !ss_dir_up_r) begin
            state_r <= bss_pkg::ST_CHARGE;
          end
        end
        default: begin
          state_r <= bss_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Boot phase counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_cnt_r <= '0;
    end else if (state_r == bss_pkg::ST_BOOT) begin
      boot_cnt_r <= boot_cnt_r + 1'b1;
    end else begin
      boot_cnt_r <= '0;
    end
  end

  // Hiccup charge/discharge cycle counting
  // count node cycles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ss_dir_up_r  <= 1'b0;
      hiccup_cnt_r <= '0;
    end else if (state_r != bss_pkg::ST_HICCUP) begin
      ss_dir_up_r  <= 1'b0;
      hiccup_cnt_r <= '0;
    end else if (!ss_dir_up_r && cmp_r.ss_low && hiccup_cnt_r != 2'(bss_pkg::HICCUP_CYCLES)) begin
      ss_dir_up_r <= 1'b1;
    end else if (ss_dir_up_r && cmp_r.ss_high) begin
      ss_dir_up_r  <= 1'b0;
      hiccup_cnt_r <= hiccup_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent blanking and filtering

  logic hs_on_r;
  logic ls_on_r;
  logic [3:0] hs_blank_r;
  logic [3:0] ls_blank_r;
  logic [3:0] hs_filt_r;
  logic [3:0] lss_filt_r;
  logic [3:0] lsk_filt_r;
  logic hs_fault;
  logic lss_fault;
  logic lsk_fault;
  logic ov_live;
  logic uv_live;

  // Filter counter step: count while raw and window open
  function automatic logic [3:0] filt_step(input logic [3:0] cnt, input logic active);
    if (!active) begin
      filt_step = '0;
    end else if (cnt != 4'(bss_pkg::FILTER_CYC)) begin
      filt_step = cnt + 4'h1;
    end else begin
      filt_step = cnt;
    end
  endfunction

  // Blanking counters restart at each conduction start
  // blank leading edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hs_blank_r <= '0;
      ls_blank_r <= '0;
    end else begin
      hs_blank_r <= !hs_on_r ? 4'h0 :
                    (hs_blank_r != 4'(bss_pkg::BLANK_CYC)) ? hs_blank_r + 4'h1 : hs_blank_r;
      ls_blank_r <= !ls_on_r ? 4'h0 :
                    (ls_blank_r != 4'(bss_pkg::BLANK_CYC)) ? ls_blank_r + 4'h1 : ls_blank_r;
    end
  end

  // Noise filters on each fault path, only with drivers on
  // filter comparator result
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hs_filt_r  <= '0;
      lss_filt_r <= '0;
      lsk_filt_r <= '0;
    end else begin
      hs_filt_r  <= filt_step(hs_filt_r, drivers_on && hs_on_r &&
                              hs_blank_r == 4'(bss_pkg::BLANK_CYC) && cmp_r.hs_source_oc);
      lss_filt_r <= filt_step(lss_filt_r, drivers_on && ls_on_r &&
                              ls_blank_r == 4'(bss_pkg::BLANK_CYC) && cmp_r.ls_source_oc);
      lsk_filt_r <= filt_step(lsk_filt_r, drivers_on && ls_on_r &&
                              ls_blank_r == 4'(bss_pkg::BLANK_CYC) && cmp_r.ls_sink_oc);
    end
  end

  assign hs_fault  = hs_filt_r == 4'(bss_pkg::FILTER_CYC);
  assign lss_fault = lss_filt_r == 4'(bss_pkg::FILTER_CYC);
  assign lsk_fault = lsk_filt_r == 4'(bss_pkg::FILTER_CYC);
  assign src_fault = (hs_fault || lss_fault) && !ov_live;

  ////////////////////////////////////////////////////////////////////////////
  // Voltage faults and sinking hold

  logic [1:0] sink_cnt_r;
  logic sink_hold_r;

  assign ov_live = (state_r == bss_pkg::ST_RUN) && cmp_r.over_v;
  assign uv_live = (state_r == bss_pkg::ST_RUN) && cmp_r.under_v;

  // Sinking fault hold over three switching clocks
  // non-synchronous hold
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sink_hold_r <= 1'b0;
      sink_cnt_r  <= '0;
    end else if (!drivers_on || ov_live) begin
      sink_hold_r <= 1'b0;
      sink_cnt_r  <= '0;
    end else if (lsk_fault && !sink_hold_r) begin
      sink_hold_r <= 1'b1;
      sink_cnt_r  <= '0;
    end else if (sink_hold_r && sw_tick) begin
      if (sink_cnt_r == 2'(bss_pkg::SINK_HOLD_CYCLES - 1)) begin
        sink_hold_r <= 1'b0;
      end
      sink_cnt_r <= sink_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bootstrap refresh

  logic [5:0] nolow_cnt_r;
  logic       refresh_r;

  // Count switching clocks without a low pulse
  // force low-side refresh
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nolow_cnt_r <= '0;
      refresh_r   <= 1'b0;
    end else if (ls_on_r || !drivers_on) begin
      nolow_cnt_r <= '0;
      refresh_r   <= 1'b0;
    end else if (sw_tick) begin
      if (nolow_cnt_r == 6'(bss_pkg::REFRESH_CYCLES - 1)) begin
        refresh_r   <= 1'b1;
        nolow_cnt_r <= '0;
      end else begin
        nolow_cnt_r <= nolow_cnt_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate drives

  // Gate selection with fault priorities
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hs_on_r <= 1'b0;
      ls_on_r <= 1'b0;
    end else if (!drivers_on || src_fault) begin
      hs_on_r <= 1'b0;
      ls_on_r <= 1'b0;
    end else if (ov_live) begin
      hs_on_r <= 1'b0;
      ls_on_r <= 1'b1;
    end else if (state_r == bss_pkg::ST_BOOT || refresh_r) begin
      // low side before any high pulse
      hs_on_r <= 1'b0;
      ls_on_r <= 1'b1;
    end else begin
      hs_on_r <= pwm_high;
      ls_on_r <= !pwm_high && !sink_hold_r;
    end
  end

  assign high_gate_drive = hs_on_r;
  assign low_gate_drive  = ls_on_r;

  ////////////////////////////////////////////////////////////////////////////
  // Soft-start node control and status

  logic good_r;
  logic [bss_pkg::CNT_W-1:0] good_cnt_r;

  // Soft-start node steering
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ss_charge_en  <= 1'b0;
      ss_discharge  <= 1'b0;
      ss_target_ref <= 1'b0;
      ss_done       <= 1'b0;
    end else begin
      // charge in every state but idle, in hiccup only on up ramps
      ss_charge_en  <= state_r != bss_pkg::ST_IDLE &&
                       (state_r != bss_pkg::ST_HICCUP || ss_dir_up_r);
      ss_discharge  <= state_r == bss_pkg::ST_IDLE ||
                       (state_r == bss_pkg::ST_HICCUP && !ss_dir_up_r);
      ss_target_ref <= drivers_on;
      ss_done       <= state_r == bss_pkg::ST_RUN;
    end
  end

  // Power good delay and immediate drop
  // gated by done
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      good_cnt_r <= '0;
      good_r     <= 1'b0;
    end else if (state_r != bss_pkg::ST_RUN || ov_live || uv_live || src_fault) begin
      good_cnt_r <= '0;
      good_r     <= 1'b0;
    end else if (good_cnt_r == bss_pkg::CNT_W'(GOOD_DELAY_CYC - 1)) begin
      good_r <= 1'b1;
    end else begin
      good_cnt_r <= good_cnt_r + 1'b1;
    end
  end

  // Status flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overvoltage_flag    <= 1'b0;
      undervoltage_flag   <= 1'b0;
      overcurrent_protect <= 1'b0;
    end else begin
      overvoltage_flag    <= ov_live;
      undervoltage_flag   <= uv_live;
      overcurrent_protect <= src_fault || state_r == bss_pkg::ST_HICCUP || sink_hold_r;
    end
  end

  // Open-drain low when not good
  assign power_ok_output_n = good_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_boot_start;
    $rose(state_r == bss_pkg::ST_BOOT);
  endsequence

  AST_START_QUAL: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == bss_pkg::ST_IDLE && !power_ok) |=> state_r == bss_pkg::ST_IDLE)
    else $error("Started without qualified supplies");
  AST_NO_DRIVE_CHARGE: assert property (@(posedge clk) disable iff (!nrst)
    state_r == bss_pkg::ST_CHARGE |=> !hs_on_r)
    else $error("High side on during charge phase");
  AST_BOOT_LOW: assert property (@(posedge clk) disable iff (!nrst)
    s_boot_start |=> (ls_on_r && !hs_on_r) [*8])
    else $error("Boot phase not low side");
  AST_GOOD_AFTER_DONE: assert property (@(posedge clk) disable iff (!nrst)
    good_r |-> $past(state_r == bss_pkg::ST_RUN))
    else $error("Power good before done");
  AST_GOOD_DROP: assert property (@(posedge clk) disable iff (!nrst)
    (good_r && (ov_live || uv_live)) |=> !good_r)
    else $error("Power good not dropped");
  AST_OV_ZERO_DUTY: assert property (@(posedge clk) disable iff (!nrst)
    (ov_live && drivers_on) |=> (!hs_on_r && ls_on_r))
    else $error("Overvoltage not zero duty");
  AST_SRC_OFF: assert property (@(posedge clk) disable iff (!nrst)
    src_fault |=> (!hs_on_r && !ls_on_r && state_r == bss_pkg::ST_HICCUP))
    else $error("Sourcing fault did not stop gates");
  AST_SINK_LS_OFF: assert property (@(posedge clk) disable iff (!nrst)
    (sink_hold_r && !ov_live && drivers_on && !refresh_r && state_r != bss_pkg::ST_BOOT) |=> !ls_on_r)
    else $error("Low side on during sinking hold");

endmodule

// File: src/bss_pkg.sv
// Package for the buck soft-start and fault sequencer
package bss_pkg;

  // Clock and timing
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned BOOT_CHARGE_NS   = 200;
  localparam int unsigned BOOT_CHARGE_CYC  = (BOOT_CHARGE_NS * CLK_MHZ) / 1000;
  localparam int unsigned BLANK_NS         = 120;
  localparam int unsigned BLANK_CYC        = (BLANK_NS * CLK_MHZ) / 1000;
  localparam int unsigned FILTER_NS        = 120;
  localparam int unsigned FILTER_CYC       = (FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned GOOD_DELAY_US    = 5000;
  localparam int unsigned GOOD_DELAY_CYC   = GOOD_DELAY_US * CLK_MHZ;
  localparam int unsigned HICCUP_CYCLES    = 3;
  localparam int unsigned SINK_HOLD_CYCLES = 3;
  localparam int unsigned REFRESH_CYCLES   = 32;
  localparam int unsigned CNT_W            = 24;

  // Synchronised comparator inputs
  typedef struct packed {
    logic supplies_ok;
    logic enable_ok;
    logic comp_above_ramp;
    logic ss_settled;
    logic ss_low;
    logic ss_high;
    logic over_v;
    logic under_v;
    logic ls_source_oc;
    logic ls_sink_oc;
    logic hs_source_oc;
  } bss_cmp_s;

  // Sequencer states
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_CHARGE = 6'h02,
    ST_BOOT   = 6'h04,
    ST_RAMP   = 6'h08,
    ST_RUN    = 6'h10,
    ST_HICCUP = 6'h20
  } bss_state_e;

endpackage

// File: test/bss_plant_model.sv
// Soft-start node and comparator model facing the sequencer
`timescale 1ns/1ps
module bss_plant_model (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Sequencer outputs
  input  wire logic              hi_on,
  input  wire logic              lo_on,
  input  wire logic              chg,
  input  wire logic              dis,
  input  wire logic              tref,
  // Bench fault requests
  input  wire logic [6:0]        req,
  // Comparator levels
  output bss_pkg::bss_cmp_s      cmp
);
  int node;
  int tgt;

  // Node target: supply level or reference
  assign tgt = tref ? 128 : 255;

  // Node steps one count a cycle toward its target, or toward zero when discharging
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      node <= 0;
    end else if (dis) begin
      node <= node - int'(node > 0);
    end else if (chg) begin
      node <= node + int'(node < tgt) - int'(node > tgt);
    end
  end

  // Comparators; current is sensed only across a conducting switch
  always_comb begin
    cmp                 = '0;
    cmp.supplies_ok     = req[0];
    cmp.enable_ok       = req[1];
    cmp.comp_above_ramp = node >= 64;
    cmp.ss_settled      = tref && node == 128;
    cmp.ss_low          = node <= 4;
    cmp.ss_high         = node >= 250;
    cmp.over_v          = req[2];
    cmp.under_v         = req[3];
    cmp.ls_source_oc    = req[4] && lo_on;
    cmp.ls_sink_oc      = req[5] && lo_on;
    cmp.hs_source_oc    = req[6] && hi_on;
  end
endmodule

// File: test/bss_sequencer_tb.sv
// Self-checking bench for the soft-start and fault sequencer
`timescale 1ns/1ps
module bss_sequencer_tb;
  localparam int GD = 50;
  logic              clk;
  logic              nrst;
  logic              sw_tick;
  logic              pwm_high;
  logic [6:0]        req;
  bss_pkg::bss_cmp_s cmp;
  logic [9:0]        ob;
  logic              hg, lg, ce, ds, tr, sd, pg, ovf, uvf, oc;
  int                mismatches = 0;
  int                num_checks = 0;
  int                tc = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock and switching tick
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial sw_tick = 1'b0;
  always @(posedge clk) begin
    #1;
    tc = (tc + 1) % 10;
    sw_tick = (tc == 0);
  end

  assign ob = {uvf, ovf, ds, ce, pg, sd, oc, tr, lg, hg};

  ////////////////////////////////////////////////////////////////////////
  // Design and far side
  bss_sequencer #(.GOOD_DELAY_CYC(GD)) dut_u (
    .clk                 (clk),
    .nrst                (nrst),
    .cmp_in              (cmp),
    .sw_tick             (sw_tick),
    .pwm_high            (pwm_high),
    .high_gate_drive     (hg),
    .low_gate_drive      (lg),
    .ss_charge_en        (ce),
    .ss_discharge        (ds),
    .ss_target_ref       (tr),
    .ss_done             (sd),
    .power_ok_output_n   (pg),
    .overvoltage_flag    (ovf),
    .undervoltage_flag   (uvf),
    .overcurrent_protect (oc)
  );

  bss_plant_model plant_u (
    .clk   (clk),
    .nrst  (nrst),
    .hi_on (hg),
    .lo_on (lg),
    .chg   (ce),
    .dis   (ds),
    .tref  (tr),
    .req   (req),
    .cmp   (cmp)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Wait for an output bit to reach a level, counting cycles
  task automatic wait_lvl(input int b, input logic v, input int lim, output int n);
    n = 0;
    while (ob[b] !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        check(ob[b], v);
        tally_and_finish();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_startup();
    int n;
    req = 7'h0d;
    cyc(40);
    check({ob[6], ob[1:0]}, 0);
    req = 7'h0f;
    wait_lvl(6, 1'b1, 10, n);
    check(ob[1:0], 0);
    check(ob[9:8], 0);
    req = 7'h03;
    wait_lvl(1, 1'b1, 200, n);
    check(ob[0], 0);
    wait_lvl(1, 1'b0, 40, n);
    check(n, bss_pkg::BOOT_CHARGE_CYC);
    check(ob[2], 1);
    wait_lvl(4, 1'b1, 300, n);
    check(ob[5], 0);
    wait_lvl(5, 1'b1, GD + 10, n);
    check(n inside {[GD - 1:GD + 3]}, 1);
  endtask

  task automatic s_uv();
    int n;
    req = 7'h0b;
    wait_lvl(5, 1'b0, 5, n);
    check(ob[9], 1);
    check(ob[4], 1);
    req = 7'h03;
    wait_lvl(5, 1'b1, GD + 10, n);
  endtask

  task automatic s_ov();
    int n;
    pwm_high = 1'b0;
    req = 7'h27;
    cyc(5);
    repeat (40) begin
      cyc(1);
      check({ob[8], ob[5], ob[1:0]}, 4'b1010);
    end
    req = 7'h03;
    wait_lvl(5, 1'b1, GD + 10, n);
  endtask

  task automatic s_hs_oc();
    int n;
    int hits;
    logic prev;
    pwm_high = 1'b1;
    cyc(40);
    req = 7'h43;
    cyc(8);
    req = 7'h03;
    cyc(10);
    check(ob[3], 0);
    pwm_high = 1'b0;
    cyc(5);
    req = 7'h43;
    pwm_high = 1'b1;
    wait_lvl(0, 1'b1, 5, n);
    wait_lvl(3, 1'b1, 40, n);
    check(n inside {[24:32]}, 1);
    req = 7'h03;
    cyc(4);
    check({ob[7], ob[5], ob[1:0]}, 4'b1000);
    hits = 0;
    prev = cmp.ss_high;
    for (n = 0; n < 4000 && ob[1] !== 1'b1; n++) begin
      cyc(1);
      hits += int'(cmp.ss_high && !prev);
      prev = cmp.ss_high;
    end
    check(hits, 3);
    wait_lvl(5, 1'b1, 400, n);
  endtask

  task automatic s_sink();
    int n;
    pwm_high = 1'b0;
    cyc(30);
    req = 7'h23;
    wait_lvl(1, 1'b0, 40, n);
    req = 7'h03;
    check(ob[0], 0);
    wait_lvl(1, 1'b1, 60, n);
    check(n inside {[15:45]}, 1);
    check(ob[4], 1);
  endtask

  task automatic s_refresh();
    int n;
    pwm_high = 1'b1;
    wait_lvl(1, 1'b0, 5, n);
    wait_lvl(1, 1'b1, 400, n);
    wait_lvl(1, 1'b0, 5, n);
    wait_lvl(1, 1'b1, 400, n);
    check(n inside {[305:335]}, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0;
    req = 7'h00;
    pwm_high = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    s_startup();
    s_uv();
    s_ov();
    s_hs_oc();
    s_sink();
    s_refresh();
    tally_and_finish();
  end
endmodule
